// ==== bench/erc_top_test.sv ====
// Purpose: Self-checking bench for the egress rate and default tag bank.
// Assumes: Strobe register port with read data one cycle after the strobe.
// Notes:   Shaper delays are checked within one cycle of tick phase.
`timescale 1ns/1ps
`default_nettype none
`include "erc_consts.svh"
module erc_top_test;
  import erc_pkg::*;
  logic         core_clk;
  logic         rst_n;
  logic [15:0]  reg_addr;
  logic         reg_wr;
  logic         reg_rd;
  logic [31:0]  reg_wdata;
  logic [31:0]  reg_rdata;
  logic         reg_rvalid;
  logic [11:0]  q_sent;
  logic [143:0] q_len;
  logic [11:0]  q_allow;
  logic [11:0]  def_vid;
  logic [2:0]   def_pri;
  int           mismatches = 0;
  int           compares = 0;

  erc_top i_dut (.core_clk_i(core_clk), .rst_n_i(rst_n),
    .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
    .reg_rvalid_o(reg_rvalid), .q_sent_i(q_sent), .q_len_i(q_len),
    .q_allow_o(q_allow), .p0_def_vid_o(def_vid), .p0_def_pri_o(def_pri));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // Read data is sampled in the single cycle that the valid pulse stands.
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    chk("rvalid", 32'h1, {31'h0, reg_rvalid});
    chk("rdata", exp, reg_rdata);
  endtask : rd

  // Write then read the same index on the next cycle, back to back.
  task automatic wr_rd(input logic [15:0] a, input logic [31:0] d,
                       input logic [31:0] exp);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    @(posedge core_clk);
    reg_rd    <= 1'b0;
    #1;
    chk("rvalid b2b", 32'h1, {31'h0, reg_rvalid});
    chk("rdata b2b", exp, reg_rdata);
  endtask : wr_rd

  // Send one frame on queue g and time how long the queue stays blocked.
  task automatic shape(input int g, input logic [11:0] len, input int exp);
    int n;
    n = 0;
    @(posedge core_clk);
    q_sent[g]           <= 1'b1;
    q_len[g*12 +: 12]   <= len;
    @(posedge core_clk);
    q_sent[g]           <= 1'b0;
    #1;
    chk("allow drop", 32'h0, {31'h0, q_allow[g]});
    while (q_allow[g] !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= 200) begin
      mismatches++;
      report_and_stop();
    end
    compares++;
    if (n < exp - 1 || n > exp + 1) begin
      mismatches++;
      $display("ERROR shaper gap expected %0d seen %0d", exp, n);
    end
  endtask : shape

  initial begin
    rst_n = 1'b0;
    reg_addr = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 32'h0;
    q_sent = 12'h000;
    q_len = '0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) rd(16'h1c0d + 16'(i), 32'h0);
    rd(`ERC_IDX_DEF_TAG0, 32'h1);
    chk("vid", 32'h1, {20'h0, def_vid});
    chk("pri", 32'h0, {29'h0, def_pri});
    chk("allow rst", 32'hfff, {20'h0, q_allow});
    for (int i = 0; i < 6; i++) wr(16'h1c0d + 16'(i), 32'hffffffff);
    for (int i = 0; i < 6; i++) rd(16'h1c0d + 16'(i), 32'h03ffffff);
    for (int i = 0; i < 6; i++)
      wr(16'h1c0d + 16'(i), {6'h3f, 13'(2 * i + 1), 13'(2 * i)});
    for (int i = 0; i < 6; i++)
      rd(16'h1c0d + 16'(i), {6'h0, 13'(2 * i + 1), 13'(2 * i)});
    wr(`ERC_IDX_DEF_TAG0, 32'hffffffff);
    rd(`ERC_IDX_DEF_TAG0, 32'h00007fff);
    wr(`ERC_IDX_DEF_TAG0, 32'h00002005);
    rd(`ERC_IDX_DEF_TAG0, 32'h00002005);
    chk("vid", 32'h5, {20'h0, def_vid});
    chk("pri", 32'h2, {29'h0, def_pri});
    // An unmapped index must neither answer with data nor disturb a field.
    wr(16'h1c14, 32'hffffffff);
    rd(16'h1c14, 32'h0);
    rd(`ERC_IDX_DEF_TAG0, 32'h00002005);
    wr_rd(`ERC_IDX_RATE_P1Q23, 32'hfd554aaa, 32'h01554aaa);
    // Queue g, other than 6 and 7, now holds rate g, so its gap is (g+1)*len*2 cycles.
    shape(0, 12'd3, 1 * 3 * 2);
    shape(1, 12'd2, 2 * 2 * 2);
    shape(11, 12'd1, 12 * 1 * 2);
    report_and_stop();
  end
endmodule : erc_top_test
`default_nettype wire

// ==== rtl/erc_consts.svh ====
// Purpose: Offsets, fields, reset values and timing of the egress config bank.
// Assumes: Register numbers are word indices on the switch register port.
// Notes:   Included by both design files.
`ifndef ERC_CONSTS_SVH
`define ERC_CONSTS_SVH
`define ERC_ADDR_W         16
`define ERC_IDX_RATE_P0Q01 16'h1c0d
`define ERC_IDX_RATE_P0Q23 16'h1c0e
`define ERC_IDX_RATE_P1Q01 16'h1c0f
`define ERC_IDX_RATE_P1Q23 16'h1c10
`define ERC_IDX_RATE_P2Q01 16'h1c11
`define ERC_IDX_RATE_P2Q23 16'h1c12
`define ERC_IDX_DEF_TAG0   16'h1c13
`define ERC_RATE_W         13
`define ERC_RATE_LO_LSB    0
`define ERC_RATE_HI_LSB    13
`define ERC_RATE_RST       13'h0000
`define ERC_VID_LSB        0
`define ERC_VID_W          12
`define ERC_PRI_LSB        12
`define ERC_PRI_W          3
`define ERC_VID_RST        12'h001
`define ERC_PRI_RST        3'h0
`define ERC_STEP_NS        20
`define ERC_CLK_NS         10
`define ERC_STEP_CYC       ((`ERC_STEP_NS + `ERC_CLK_NS - 1) / `ERC_CLK_NS)
`endif

// ==== rtl/erc_pkg.sv ====
// Purpose: Types shared by the egress config bank.
// Assumes: None.
// Notes:   Constants live in erc_consts.svh.
package erc_pkg;
  typedef enum logic [1:0] {
    ERC_IDLE = 2'b01,
    ERC_WAIT = 2'b10
  } erc_shp_e;
endpackage : erc_pkg

// ==== rtl/erc_shaper.sv ====
// Purpose: Per-queue byte-time shaper that gates the next frame.
// Assumes: Byte counts arrive as a pulse with the sent length.
// Notes:   One instance per queue.
`timescale 1ns/1ps
`default_nettype none
`include "erc_consts.svh"
module erc_shaper
  import erc_pkg::*;
#(
  parameter int RATE_W = 13,
  parameter int LEN_W  = 12
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [RATE_W-1:0] rate_i,
  input  wire logic              sent_i,
  input  wire logic [LEN_W-1:0]  sent_len_i,
  output logic                   allow_o
);
  localparam int CNT_W = RATE_W + LEN_W + 4;
  localparam int STEP_W = 4;
  initial begin
    if (RATE_W < 1 || LEN_W < 1 || CNT_W > 40) begin
      $error("erc_shaper: unsupported widths");
    end
  end
  // One step of the per-byte interval lasts ERC_STEP_CYC clocks.
  localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(`ERC_STEP_CYC - 1);
  logic [STEP_W-1:0] step_q;
  logic [CNT_W-1:0]  credit_q;
  erc_shp_e          st_q;
  wire logic         tick = (step_q == STEP_LAST);
  // Time owed is (rate + 1) steps per byte sent.
  wire logic [CNT_W-1:0] owed =
    CNT_W'((RATE_W+1)'(rate_i) + 1'b1) * CNT_W'(sent_len_i);
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      step_q   <= '0;
      credit_q <= '0;
      st_q     <= ERC_IDLE;
    end else begin
      step_q <= tick ? '0 : step_q + 1'b1;
      unique case (st_q)
        ERC_IDLE: begin
          if (sent_i && sent_len_i != '0) begin
            credit_q <= owed;
            st_q     <= ERC_WAIT;
          end
        end
        ERC_WAIT: begin
          if (tick) begin
            credit_q <= credit_q - 1'b1;
            if (credit_q == CNT_W'(1)) begin
              st_q <= ERC_IDLE;
            end
          end
        end
      endcase
    end
  end
  assign allow_o = (st_q == ERC_IDLE);
  a_hold_wait: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (st_q == ERC_IDLE && sent_i && sent_len_i != '0) |=> !allow_o)
    else $error("queue not held after a frame");
  a_credit_load: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (st_q == ERC_IDLE && sent_i && sent_len_i != '0)
      |=> credit_q == $past(owed))
    else $error("credit not loaded with rate plus one times length");
endmodule : erc_shaper
`default_nettype wire

// ==== rtl/erc_top.sv ====
// Purpose: Egress rate and port 0 default tag registers of the buffer manager.
// Assumes: Register port: word index, write strobe, read strobe, 32-bit data.
// Notes:   Reads return data one cycle after the read strobe.
// Behaviour
// - Each rate field means a time per byte of (value plus one) times 20 ns.
// - Two 13-bit rates per register: odd queue in 25:13, even queue in 12:0.
// - All rate fields are read/write and reset to zero.
// - Default priority in bits 14:12, reset zero, is applied to egress tags.
// - Default VLAN ID in bits 11:0, reset one, is applied to egress tags.
// - Bits 31:15 of the default tag register are reserved and read zero.
`timescale 1ns/1ps
`default_nettype none
`include "erc_consts.svh"
module erc_top
  import erc_pkg::*;
#(
  parameter int NPORT = 3,
  parameter int NQUE  = 4,
  parameter int LEN_W = 12
) (
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic [`ERC_ADDR_W-1:0]    reg_addr_i,
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  input  wire logic [31:0]               reg_wdata_i,
  output logic      [31:0]               reg_rdata_o,
  output logic                           reg_rvalid_o,
  input  wire logic [NPORT*NQUE-1:0]     q_sent_i,
  input  wire logic [NPORT*NQUE*LEN_W-1:0] q_len_i,
  output logic      [NPORT*NQUE-1:0]     q_allow_o,
  output logic      [`ERC_VID_W-1:0]     p0_def_vid_o,
  output logic      [`ERC_PRI_W-1:0]     p0_def_pri_o
);
  localparam int NRATE = NPORT * NQUE;
  localparam int NREG  = NRATE / 2;
  initial begin
    if (NPORT != 3 || NQUE != 4 || LEN_W < 1) begin
      $error("erc_top: map is fixed at three ports of four queues");
    end
  end

  logic [`ERC_RATE_W-1:0] rate_q [NRATE];
  logic [`ERC_VID_W-1:0]  vid_q;
  logic [`ERC_PRI_W-1:0]  pri_q;
  logic [31:0]            rdata_q;
  logic                   rvalid_q;

  // Rate registers occupy consecutive indices from the first one.
  wire logic [`ERC_ADDR_W-1:0] rate_off = reg_addr_i - `ERC_IDX_RATE_P0Q01;
  wire logic hit_rate = (reg_addr_i >= `ERC_IDX_RATE_P0Q01) &&
                        (reg_addr_i <= `ERC_IDX_RATE_P2Q23);
  wire logic hit_tag  = (reg_addr_i == `ERC_IDX_DEF_TAG0);
  wire logic [3:0] rsel = rate_off[3:0];

  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_rate
      wire logic wr_here = reg_wr_i && hit_rate && (rsel == 4'(g));
      always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          rate_q[2*g]   <= `ERC_RATE_RST;
          rate_q[2*g+1] <= `ERC_RATE_RST;
        end else if (wr_here) begin
          rate_q[2*g]   <= reg_wdata_i[`ERC_RATE_LO_LSB +: `ERC_RATE_W];
          rate_q[2*g+1] <= reg_wdata_i[`ERC_RATE_HI_LSB +: `ERC_RATE_W];
        end
      end
    end
    for (g = 0; g < NRATE; g++) begin : g_shp
      erc_shaper #(
        .RATE_W (`ERC_RATE_W),
        .LEN_W  (LEN_W)
      ) u_shp (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .rate_i     (rate_q[g]),
        .sent_i     (q_sent_i[g]),
        .sent_len_i (q_len_i[g*LEN_W +: LEN_W]),
        .allow_o    (q_allow_o[g])
      );
    end
  endgenerate

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vid_q <= `ERC_VID_RST;
      pri_q <= `ERC_PRI_RST;
    end else if (reg_wr_i && hit_tag) begin
      // Reserved bits 31:15 are dropped on write.
      vid_q <= reg_wdata_i[`ERC_VID_LSB +: `ERC_VID_W];
      pri_q <= reg_wdata_i[`ERC_PRI_LSB +: `ERC_PRI_W];
    end
  end

  // Read mux: unmapped indices and reserved bits return zero.
  wire logic [31:0] rate_word =
    {6'h00, rate_q[2*rsel+1], rate_q[2*rsel]};
  wire logic [31:0] tag_word = {17'h00000, pri_q, vid_q};
  wire logic [31:0] rd_mux = hit_rate ? rate_word :
                             hit_tag  ? tag_word  : 32'h00000000;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q  <= 32'h00000000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd_i;
      if (reg_rd_i) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign reg_rdata_o  = rdata_q;
  assign reg_rvalid_o = rvalid_q;
  assign p0_def_vid_o = vid_q;
  assign p0_def_pri_o = pri_q;

  a_tag_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (reg_wr_i && hit_tag) |=> (p0_def_vid_o == $past(reg_wdata_i[11:0]) &&
      p0_def_pri_o == $past(reg_wdata_i[14:12])))
    else $error("default tag write not applied");
  a_tag_resv: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (reg_rd_i && hit_tag) |=> reg_rdata_o[31:15] == 17'h00000)
    else $error("reserved tag bits not zero");
  a_rate_resv: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (reg_rd_i && hit_rate) |=> reg_rdata_o[31:26] == 6'h00)
    else $error("reserved rate bits not zero");
  a_rate_rdbk: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (reg_wr_i && reg_addr_i == `ERC_IDX_RATE_P1Q23) ##1
    (reg_rd_i && reg_addr_i == `ERC_IDX_RATE_P1Q23)
      |=> reg_rdata_o[25:0] == $past(reg_wdata_i[25:0], 2))
    else $error("rate readback mismatch");
  a_vid_reset: assert property (@(posedge core_clk_i)
    $rose(rst_n_i) |-> p0_def_vid_o == 12'h001)
    else $error("default VLAN ID not one after reset");
  a_rate_reset: assert property (@(posedge core_clk_i)
    $rose(rst_n_i) |-> rate_q[0] == 13'h0000)
    else $error("rate not zero after reset");
endmodule : erc_top
`default_nettype wire
